/* mrbs_bank.sv */
`timescale 1ns/1ps
`include "mrbs_cfg.svh"

// Contract
// - Read-only bits read back; management writes to them change nothing.
// - Override-gated bits always readable; writes dropped while override bit is zero.
// - With override bit set, next register write updates override-gated bits only if it targets the extended register.
// - Override bit clears itself when the next register write completes.
// - Plain read/write bits store every write and return it on read.
// - Zero-only-write bits readable; writes may clear them but never set them.
// - Every reset loads each bit having a default with that default.
// - Strap-dependent defaults come from address/indicator pins sampled at reset.
// - Sticky-set bit captures one on event, holds until reset or read.
// - After reading, sticky-set bit reloads the monitored signal's present level.
// - Sticky-clear bit captures zero on event, holds until reset or read.
// - After reading, sticky-clear bit reloads the active-low signal's present level.
// - Peak-hold group updates only when the state value exceeds held value.
// - Peak-hold keeps maximum until reset or read, then loads present value.
// - Writing one to trigger bit starts function; bit clears when done.
// - Trigger bits reset to zero; zero means nothing in progress.
// - Entering low power keeps registers but returns sticky bits to defaults.

module mrbs_bank (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                mgmt_rd_req,
  input  wire logic                mgmt_wr_req,
  input  wire logic [4:0]          mgmt_addr,
  input  wire logic [15:0]         mgmt_wdata,
  input  wire mrbs_pkg::mrbs_mon_s mon,
  input  wire logic                an_restart_done,
  input  wire logic                strap_addr0_indicator_pin,
  input  wire logic                strap_addr1_indicator_pin,
  input  wire logic                strap_addr2_indicator_pin,
  input  wire logic                strap_addr3_indicator_pin,
  input  wire logic                strap_addr4_indicator_pin,
  output logic [15:0]              mgmt_rdata,
  output logic                     mgmt_rd_valid,
  output logic                     mgmt_wr_ack,
  output mrbs_pkg::mrbs_ctl_s      ctl
);

  // ========================================================================
  // Declarations
  // ========================================================================
  logic [4:0]  strap_sync;
  logic [4:0]  strap_r;
  logic        strap_pend_r;
  logic        loop_r;
  logic        speed_r;
  logic        anen_r;
  logic        lowpwr_r;
  logic        iso_r;
  logic        duplex_r;
  logic        coltst_r;
  logic        ovr_r;
  logic [3:0]  test_r;
  logic [4:0]  addr_r;
  logic        zow_r;
  logic [2:0]  sset_r;
  logic [2:0]  sset_nxt;
  logic        sclr_r;
  logic        sclr_nxt;
  logic [2:0]  peak_r;
  logic [2:0]  peak_nxt;
  logic        ovr_nxt;
  logic        zow_nxt;
  logic [`MRBS_CNT_W-1:0] swrst_cnt_r;
  logic        swrst_busy;
  logic        anrst_busy;
  logic [15:0] rdata_r;
  logic        rd_valid_r;
  logic        wr_ack_r;

  // ========================================================================
  // Strap pins: synchronise, then latch once after reset release
  // ========================================================================
  // Pins sit outside the clock domain, two flops before any use
  mrbs_sync #(
    .W (5)
  ) u_strap_sync (
    .clk (clk),
    .d   ({strap_addr4_indicator_pin, strap_addr3_indicator_pin,
           strap_addr2_indicator_pin, strap_addr1_indicator_pin,
           strap_addr0_indicator_pin}),
    .q   (strap_sync)
  );

  // Capture cycle right after release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_pend_r <= 1'b1;
      strap_r      <= `MRBS_ADDR_ZERO;
    end else if (strap_pend_r) begin
      strap_pend_r <= 1'b0;
      strap_r      <= strap_sync;
    end
  end

  // ========================================================================
  // Access decode
  // ========================================================================
  // Accesses are isolated during strap capture and software reset
  wire acc_ok   = ~strap_pend_r & ~swrst_busy;
  wire rd_hit   = mgmt_rd_req & acc_ok;
  wire wr_hit   = mgmt_wr_req & ~mgmt_rd_req & acc_ok;  // Read has priority

  // Register selects
  wire sel_ctrl = (mgmt_addr == `MRBS_A_CTRL);
  wire sel_stat = (mgmt_addr == `MRBS_A_STAT);
  wire sel_ext  = (mgmt_addr == `MRBS_A_EXT);
  wire sel_dst  = (mgmt_addr == `MRBS_A_DSTAT);

  // Qualified strobes; any mapped write consumes the override
  wire wr_ctrl  = wr_hit & sel_ctrl;
  wire wr_ext   = wr_hit & sel_ext;
  wire rd_stat  = rd_hit & sel_stat;
  wire rd_dst   = rd_hit & sel_dst;
  wire wr_any   = wr_hit & (sel_ctrl | sel_stat | sel_ext | sel_dst);

  // Software reset ends on its last counted cycle
  wire swrst_fin  = swrst_busy & (swrst_cnt_r == `MRBS_CNT_W'(`MRBS_SWRST_CYC - 1));

  // Default loads from strap capture and software reset completion
  wire [4:0] def_strap = strap_pend_r ? strap_sync : strap_r;   // Live pins during capture
  wire       load_def  = strap_pend_r | swrst_fin;

  // Only a 0 to 1 write of the low-power bit counts as entry
  wire lp_enter   = wr_ctrl & mgmt_wdata[`MRBS_B_LOWPWR] & ~lowpwr_r;
  wire sticky_def = lp_enter | swrst_fin;

  // ========================================================================
  // Trigger bits: software reset and negotiation restart
  // ========================================================================
  // Software reset runs its counter, then reloads defaults
  mrbs_trig u_swrst (
    .clk   (clk),
    .rst   (rst),
    .start (wr_ctrl & mgmt_wdata[`MRBS_B_SWRST]),
    .done  (swrst_fin),
    .busy  (swrst_busy)
  );

  // Restart ends on done; a finished software reset also clears it
  mrbs_trig u_anrst (
    .clk   (clk),
    .rst   (rst | swrst_fin),
    .start (wr_ctrl & mgmt_wdata[`MRBS_B_ANRST]),
    .done  (an_restart_done),
    .busy  (anrst_busy)
  );

  // Software reset duration counter
  always_ff @(posedge clk) begin
    if (rst || !swrst_busy) begin
      swrst_cnt_r <= '0;
    end else begin
      swrst_cnt_r <= swrst_cnt_r + `MRBS_CNT_W'(1);
    end
  end

  // ========================================================================
  // Control register: plain read/write bits
  // ========================================================================
  always_ff @(posedge clk) begin
    if (rst || load_def) begin
      loop_r   <= `MRBS_DEF_LOOP;
      speed_r  <= `MRBS_DEF_SPEED;
      anen_r   <= `MRBS_DEF_ANEN;
      lowpwr_r <= `MRBS_DEF_LOWPWR;
      duplex_r <= `MRBS_DEF_DUPLEX;
      coltst_r <= `MRBS_DEF_COLTST;
    end else if (wr_ctrl) begin
      loop_r   <= mgmt_wdata[`MRBS_B_LOOP];
      speed_r  <= mgmt_wdata[`MRBS_B_SPEED];
      anen_r   <= mgmt_wdata[`MRBS_B_ANEN];
      lowpwr_r <= mgmt_wdata[`MRBS_B_LOWPWR];
      duplex_r <= mgmt_wdata[`MRBS_B_DUPLEX];
      coltst_r <= mgmt_wdata[`MRBS_B_COLTST];
    end
  end

  // Isolate default follows the strapped address
  always_ff @(posedge clk) begin
    if (rst) begin
      iso_r <= 1'b1;
    end else if (load_def) begin
      iso_r <= (def_strap == `MRBS_ADDR_ZERO);
    end else if (wr_ctrl) begin
      iso_r <= mgmt_wdata[`MRBS_B_ISO];
    end
  end

  // ========================================================================
  // Extended register: override, test, gated address, zero-only bit
  // ========================================================================
  // Override covers exactly one following write
  assign ovr_nxt = !wr_any ? ovr_r :
                   ovr_r   ? 1'b0 :
                   (wr_ext & mgmt_wdata[`MRBS_B_OVR]);

  // Hardware set wins over a clearing write
  assign zow_nxt = mon.err_event |
                   (zow_r & ~(wr_ext & ~mgmt_wdata[`MRBS_B_ZOW]));

  always_ff @(posedge clk) begin
    if (rst || load_def) begin
      ovr_r  <= `MRBS_DEF_OVR;
      test_r <= `MRBS_DEF_TEST;
      zow_r  <= `MRBS_DEF_ZOW;
    end else begin
      ovr_r  <= ovr_nxt;
      zow_r  <= zow_nxt;
      if (wr_ext) begin
        test_r <= mgmt_wdata[`MRBS_F_TEST_HI:`MRBS_F_TEST_LO];
      end
    end
  end

  // Address field is override-gated, default from straps
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= `MRBS_ADDR_ZERO;
    end else if (load_def) begin
      addr_r <= def_strap;
    end else if (wr_ext && ovr_r) begin
      addr_r <= mgmt_wdata[`MRBS_F_ADDR_HI:`MRBS_F_ADDR_LO];
    end
  end

  // ========================================================================
  // Sticky-set bits, one per monitored active-high event
  // ========================================================================
  // Event and read-strobe vectors: jabber, remote fault, rx error
  wire [2:0] sset_ev  = {mon.rx_error, mon.remote_fault, mon.jabber};
  wire [2:0] sset_rd  = {rd_dst, rd_stat, rd_stat};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sset
      // Event wins over read reload and low-power default
      assign sset_nxt[gi] = sset_ev[gi] |
                            (sset_r[gi] & ~sset_rd[gi] & ~sticky_def);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      sset_r <= `MRBS_DEF_SSET;
    end else begin
      sset_r <= sset_nxt;
    end
  end

  // ========================================================================
  // Sticky-clear bit on the active-low link signal
  // ========================================================================
  assign sclr_nxt = sticky_def ? (`MRBS_DEF_SCLR & mon.link_ok) :
                    mon.link_ok & (rd_stat | sclr_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      sclr_r <= `MRBS_DEF_SCLR;
    end else begin
      sclr_r <= sclr_nxt;
    end
  end

  // ========================================================================
  // Peak-hold group over the watched state value
  // ========================================================================
  // Group compared as one value, top bit most significant
  wire peak_up = (mon.fsm_state > peak_r);              // Unsigned compare

  assign peak_nxt = rd_dst  ? mon.fsm_state :
                    peak_up ? mon.fsm_state :
                    peak_r;

  always_ff @(posedge clk) begin
    if (rst || swrst_fin) begin
      peak_r <= `MRBS_DEF_PEAK;
    end else begin
      peak_r <= peak_nxt;
    end
  end

  // ========================================================================
  // Read words and selection
  // ========================================================================
  // Fixed and read-only fields are constants inside the words
  wire [15:0] w_ctrl = {swrst_busy, loop_r, speed_r, anen_r, lowpwr_r, iso_r,
                        anrst_busy, duplex_r, coltst_r, 7'h00};
  wire [15:0] w_stat = {`MRBS_ABILITY, 6'h00, sset_r[1], 1'b0, sclr_r,
                        sset_r[0], 1'b0};
  wire [15:0] w_ext  = {ovr_r, test_r, addr_r, zow_r, 5'h00};
  wire [15:0] w_dst  = {2'h0, peak_r, 3'h0, sset_r[2], 7'h00};

  // Unmapped indices read as all ones
  wire [15:0] rd_word = sel_ctrl ? w_ctrl :
                        sel_stat ? w_stat :
                        sel_ext  ? w_ext  :
                        sel_dst  ? w_dst  :
                        `MRBS_RD_UNMAPPED;

  // Capture read data in the same edge as the sticky reloads
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r    <= 16'h0000;
      rd_valid_r <= 1'b0;
      wr_ack_r   <= 1'b0;
    end else begin
      rd_valid_r <= rd_hit;
      wr_ack_r   <= wr_hit;
      if (rd_hit) begin
        rdata_r <= rd_word;
      end
    end
  end

  // ========================================================================
  // Outputs, all from flip-flops
  // ========================================================================
  assign mgmt_rdata    = rdata_r;
  assign mgmt_rd_valid = rd_valid_r;
  assign mgmt_wr_ack   = wr_ack_r;

  // Control levels toward the rest of the device
  assign ctl.loopback        = loop_r;
  assign ctl.speed_sel       = speed_r;
  assign ctl.an_enable       = anen_r;
  assign ctl.low_power       = lowpwr_r;
  assign ctl.isolate         = iso_r;
  assign ctl.duplex          = duplex_r;
  assign ctl.col_test        = coltst_r;
  assign ctl.phy_addr        = addr_r;
  assign ctl.test_mode       = test_r;
  assign ctl.sw_reset_busy   = swrst_busy;
  assign ctl.an_restart_busy = anrst_busy;

endmodule : mrbs_bank

/* mrbs_bank_assertions.sv */
`timescale 1ns/1ps
module mrbs_chk (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                mgmt_rd_req,
  input wire logic                mgmt_wr_req,
  input wire logic [4:0]          mgmt_addr,
  input wire logic                an_restart_done,
  input wire logic [15:0]         mgmt_rdata,
  input wire logic                mgmt_rd_valid,
  input wire logic                mgmt_wr_ack,
  input wire mrbs_pkg::mrbs_ctl_s ctl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Access answers
  a_rd_answer: assert property (
    (mgmt_rd_req && !$past(rst) && !ctl.sw_reset_busy) |=> mgmt_rd_valid)
    else $error("read not answered");
  a_wr_answer: assert property (
    (mgmt_wr_req && !mgmt_rd_req && !$past(rst) && !ctl.sw_reset_busy) |=> mgmt_wr_ack)
    else $error("write not acked");
  a_rd_cause: assert property (
    mgmt_rd_valid |-> $past(mgmt_rd_req))
    else $error("read data without request");

  // ==========================================================
  // Fixed and gated fields
  a_ro_ctrl: assert property (
    (mgmt_rd_valid && $past(mgmt_addr) == 5'h00) |-> mgmt_rdata[6:0] == 7'h00)
    else $error("control low bits not zero");
  a_ro_stat: assert property (
    (mgmt_rd_valid && $past(mgmt_addr) == 5'h01) |-> mgmt_rdata[15:11] == 5'h1f)
    else $error("status ability bits wrong");
  a_addr_hold: assert property (
    $changed(ctl.phy_addr) |-> (mgmt_wr_ack || $past(rst) || $past(rst, 2)
      || $past(ctl.sw_reset_busy) || $fell(ctl.sw_reset_busy)))
    else $error("address changed without write");
  a_iso_strap: assert property (
    ($past(rst, 2) && !$past(rst)) |-> ctl.isolate == (ctl.phy_addr == 5'h00))
    else $error("isolate not from strap");

  // ==========================================================
  // Trigger bits
  a_trig_reset: assert property (
    $fell(rst) |-> (!ctl.sw_reset_busy && !ctl.an_restart_busy))
    else $error("trigger set after reset");
  a_anrst_done: assert property (
    (ctl.an_restart_busy && an_restart_done && !mgmt_wr_req) |=> !ctl.an_restart_busy)
    else $error("restart trigger not cleared");
  a_swrst_len: assert property (
    $rose(ctl.sw_reset_busy) |-> ##124 ctl.sw_reset_busy ##1 !ctl.sw_reset_busy)
    else $error("software reset length wrong");
endmodule : mrbs_chk

bind mrbs_bank mrbs_chk chk (
  .clk             (clk),
  .rst             (rst),
  .mgmt_rd_req     (mgmt_rd_req),
  .mgmt_wr_req     (mgmt_wr_req),
  .mgmt_addr       (mgmt_addr),
  .an_restart_done (an_restart_done),
  .mgmt_rdata      (mgmt_rdata),
  .mgmt_rd_valid   (mgmt_rd_valid),
  .mgmt_wr_ack     (mgmt_wr_ack),
  .ctl             (ctl)
);

/* mrbs_bank_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("Error %s exp %h got %h", nm, ex, got); \
    end \
  end

module mrbs_bank_tb;
  logic                clk, rst, an_done, rd_req, wr_req, rd_valid, wr_ack, iso;
  logic [4:0]          addr, straps;
  logic [15:0]         wdata, rdata, e, m, w;
  mrbs_pkg::mrbs_mon_s mon;
  mrbs_pkg::mrbs_ctl_s ctl;
  int                  err_total, check_count, wr_seen, seed;

  mrbs_sta sta (.clk(clk), .rd_req(rd_req), .wr_req(wr_req), .addr(addr), .wdata(wdata));

  mrbs_bank dut (
    .clk(clk), .rst(rst), .mgmt_rd_req(rd_req), .mgmt_wr_req(wr_req),
    .mgmt_addr(addr), .mgmt_wdata(wdata), .mon(mon), .an_restart_done(an_done),
    .strap_addr0_indicator_pin(straps[0]), .strap_addr1_indicator_pin(straps[1]),
    .strap_addr2_indicator_pin(straps[2]), .strap_addr3_indicator_pin(straps[3]),
    .strap_addr4_indicator_pin(straps[4]), .mgmt_rdata(rdata),
    .mgmt_rd_valid(rd_valid), .mgmt_wr_ack(wr_ack), .ctl(ctl));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Result watcher takes the oldest note, mid-cycle when outputs are settled
  always @(negedge clk) begin
    if (wr_ack === 1'b1) wr_seen++;
    if (rd_valid === 1'b1) begin
      if (sta.exp_q.size() == 0) begin
        err_total++;
        $display("Error rdata exp none got %h", rdata);
      end else begin
        e = sta.exp_q.pop_front();
        m = sta.msk_q.pop_front();
        `CHK("rdata", e, rdata & m)
      end
    end
  end

  // ==========================================================
  // Closing
  task automatic fin(input string nm);
    sta.idle();
    repeat (2) @(negedge clk);
    `CHK("pending", 0, sta.exp_q.size())
    `CHK("acks", sta.wr_cnt, wr_seen)
    $display("Test %s done", nm);
  endtask : fin

  task automatic summarize;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    seed = 32'h15b2_c973;
    rst = 1'b1;
    an_done = 1'b0;
    mon = '0;
    mon.link_ok = 1'b1;
    straps = 5'($random(seed));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    iso = (straps == 5'h00);
    `CHK("addr", straps, ctl.phy_addr)
    `CHK("iso", iso, ctl.isolate)
    `CHK("trig", 2'h0, {ctl.sw_reset_busy, ctl.an_restart_busy})
    sta.rd(5'h00, {4'h3, 1'b0, iso, 10'h000}, 16'hffff);
    sta.rd(5'h10, {5'h00, straps, 6'h00}, 16'hffe0);
    sta.rd(5'h01, 16'hf800, 16'hf816);
    sta.rd(5'h01, 16'hf804, 16'hf816);
    sta.rd(5'h05, 16'hffff, 16'hffff);
    fin("reset");
    // Plain and read-only bits
    repeat (4) begin
      w = 16'($random(seed)) & 16'h7580;
      sta.wr(5'h00, w | 16'h007f);
      sta.rd(5'h00, w, 16'hffff);
      sta.idle();
      `CHK("ctl", {w[14], w[8], w[7]}, {ctl.loopback, ctl.duplex, ctl.col_test})
    end
    sta.wr(5'h01, 16'hffff);
    sta.rd(5'h01, 16'hf800, 16'hf800);
    fin("plain");
    // Override-gated address
    sta.wr(5'h10, 16'h07c0);
    sta.rd(5'h10, {5'h00, straps, 6'h00}, 16'hffe0);
    sta.wr(5'h10, 16'h8000);
    sta.rd(5'h10, {5'h10, straps, 6'h00}, 16'hffe0);
    sta.wr(5'h10, {5'h00, ~straps, 6'h00});
    sta.rd(5'h10, {5'h00, ~straps, 6'h00}, 16'hffe0);
    sta.wr(5'h10, {5'h00, straps, 6'h00});
    sta.wr(5'h10, 16'h8000);
    sta.wr(5'h00, 16'h3000);
    sta.wr(5'h10, {5'h00, straps, 6'h00});
    sta.rd(5'h10, {5'h00, ~straps, 6'h00}, 16'hffe0);
    fin("override");
    // Zero-only-write bit
    sta.wr(5'h10, 16'h0020);
    sta.rd(5'h10, 16'h0000, 16'h0020);
    sta.idle();
    mon.err_event = 1'b1;
    @(negedge clk) mon.err_event = 1'b0;
    sta.rd(5'h10, 16'h0020, 16'h0020);
    sta.wr(5'h10, 16'h0000);
    sta.rd(5'h10, 16'h0000, 16'h0020);
    fin("zero_only");
    // Sticky bits; rx error event on the read edge
    {mon.jabber, mon.remote_fault, mon.link_ok} = 3'h6;
    @(negedge clk) {mon.jabber, mon.remote_fault, mon.link_ok} = 3'h1;
    repeat (3) @(negedge clk);
    sta.rd(5'h01, 16'h0012, 16'h0016);
    sta.rd(5'h01, 16'h0004, 16'h0016);
    sta.rd(5'h11, 16'h0000, 16'h0080);
    mon.rx_error = 1'b1;
    sta.rd(5'h11, 16'h0080, 16'h0080);
    mon.rx_error = 1'b0;
    sta.rd(5'h11, 16'h0000, 16'h0080);
    fin("sticky");
    // Peak-hold group
    mon.fsm_state = 3'h3;
    repeat (2) @(negedge clk) mon.fsm_state = 3'h2;
    sta.rd(5'h11, 16'h1800, 16'h3800);
    sta.rd(5'h11, 16'h1000, 16'h3800);
    sta.idle();
    mon.fsm_state = 3'h4;
    @(negedge clk) mon.fsm_state = 3'h1;
    sta.rd(5'h11, 16'h2000, 16'h3800);
    sta.rd(5'h11, 16'h0800, 16'h3800);
    fin("peak");
    // Restart trigger
    sta.wr(5'h00, 16'h3200);
    sta.rd(5'h00, 16'h0200, 16'h0200);
    sta.idle();
    an_done = 1'b1;
    @(negedge clk) an_done = 1'b0;
    `CHK("anrst", 1'b0, ctl.an_restart_busy)
    sta.rd(5'h00, 16'h0000, 16'h0200);
    fin("trigger");
    // Low power clears sticky bits only
    mon.jabber = 1'b1;
    @(negedge clk) mon.jabber = 1'b0;
    sta.wr(5'h00, 16'h3800);
    sta.rd(5'h01, 16'h0000, 16'h0012);
    sta.rd(5'h00, 16'h3800, 16'hff80);
    sta.rd(5'h10, {5'h00, ~straps, 6'h00}, 16'hffe0);
    `CHK("ctl_lp", 4'he, {ctl.speed_sel, ctl.an_enable, ctl.low_power, ctl.isolate})
    `CHK("test", 4'h0, ctl.test_mode)
    sta.wr(5'h00, 16'h3000);
    fin("low_power");
    // Software reset reloads defaults
    sta.wr(5'h00, 16'hc000);
    sta.rd(5'h00, 16'h0000, 16'h0000);
    sta.idle();
    for (int i = 0; i < 400 && ctl.sw_reset_busy !== 1'b0; i++) @(negedge clk);
    `CHK("swrst", 1'b0, ctl.sw_reset_busy)
    sta.rd(5'h00, {4'h3, 1'b0, iso, 10'h000}, 16'hffff);
    sta.rd(5'h10, {5'h00, straps, 6'h00}, 16'hffe0);
    fin("sw_reset");
    summarize();
  end
endmodule : mrbs_bank_tb

/* mrbs_cfg.svh */
`ifndef MRBS_CFG_SVH
`define MRBS_CFG_SVH

// ==========================================================================
// Register indices
// ==========================================================================
`define MRBS_A_CTRL      5'h00
`define MRBS_A_STAT      5'h01
`define MRBS_A_EXT       5'h10
`define MRBS_A_DSTAT     5'h11

// ==========================================================================
// Field positions
// ==========================================================================
`define MRBS_B_SWRST     15
`define MRBS_B_LOOP      14
`define MRBS_B_SPEED     13
`define MRBS_B_ANEN      12
`define MRBS_B_LOWPWR    11
`define MRBS_B_ISO       10
`define MRBS_B_ANRST     9
`define MRBS_B_DUPLEX    8
`define MRBS_B_COLTST    7
`define MRBS_B_OVR       15
`define MRBS_F_TEST_HI   14
`define MRBS_F_TEST_LO   11
`define MRBS_F_ADDR_HI   10
`define MRBS_F_ADDR_LO   6
`define MRBS_B_ZOW       5

// ==========================================================================
// Reset values and constant fields
// ==========================================================================
`define MRBS_DEF_LOOP    1'b0
`define MRBS_DEF_SPEED   1'b1
`define MRBS_DEF_ANEN    1'b1
`define MRBS_DEF_LOWPWR  1'b0
`define MRBS_DEF_DUPLEX  1'b0
`define MRBS_DEF_COLTST  1'b0
`define MRBS_DEF_OVR     1'b0
`define MRBS_DEF_TEST    4'h0
`define MRBS_DEF_ZOW     1'b0
`define MRBS_DEF_SSET    3'h0
`define MRBS_DEF_SCLR    1'b0
`define MRBS_DEF_PEAK    3'h0
`define MRBS_ADDR_ZERO   5'h00
`define MRBS_ABILITY     5'h1f
`define MRBS_RD_UNMAPPED 16'hffff

// ==========================================================================
// Timing
// ==========================================================================
`define MRBS_CLK_NS      8
`define MRBS_SWRST_NS    1000
`define MRBS_SWRST_CYC   ((`MRBS_SWRST_NS + `MRBS_CLK_NS - 1) / `MRBS_CLK_NS)
`define MRBS_CNT_W       8

`endif

/* mrbs_pkg.sv */
package mrbs_pkg;

  // ========================================================================
  // Monitored event and state inputs, same clock domain
  // ========================================================================
  typedef struct packed {
    logic       remote_fault;  // Active-high, sticky-set in status
    logic       jabber;        // Active-high, sticky-set in status
    logic       rx_error;      // Active-high, sticky-set in detail status
    logic       link_ok;       // Active-low event: low means link lost
    logic       err_event;     // Sets the zero-only-write bit
    logic [2:0] fsm_state;     // Watched by the peak-hold group
  } mrbs_mon_s;

  // ========================================================================
  // Control outputs steering the rest of the device
  // ========================================================================
  typedef struct packed {
    logic       loopback;
    logic       speed_sel;
    logic       an_enable;
    logic       low_power;
    logic       isolate;
    logic       duplex;
    logic       col_test;
    logic [4:0] phy_addr;
    logic [3:0] test_mode;
    logic       sw_reset_busy;
    logic       an_restart_busy;
  } mrbs_ctl_s;

endpackage : mrbs_pkg

/* mrbs_sta.sv */
`timescale 1ns/1ps
module mrbs_sta (
  input wire logic        clk,
  output logic            rd_req,
  output logic            wr_req,
  output logic [4:0]      addr,
  output logic [15:0]     wdata
);
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int          wr_cnt;

  // Idle levels at time zero
  initial begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr   = 5'h00;
    wdata  = 16'h0000;
    wr_cnt = 0;
  end

  // ==========================================================
  // Requests, one per falling edge
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    @(negedge clk);
    rd_req = 1'b1;
    wr_req = 1'b0;
    addr   = a;
    if (m != 16'h0000) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
  endtask : rd

  // Test field forced to its default
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    wr_req = 1'b1;
    rd_req = 1'b0;
    addr   = a;
    wdata  = (a == 5'h10) ? {d[15], 4'h0, d[10:0]} : d;
    wr_cnt++;
  endtask : wr

  // Released lines flip so stale values never pass
  task automatic idle;
    @(negedge clk);
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr   = ~addr;
    wdata  = ~wdata;
  endtask : idle
endmodule : mrbs_sta

/* mrbs_sync.sv */
`timescale 1ns/1ps
`include "mrbs_cfg.svh"

module mrbs_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ========================================================================
  // Two-stage synchroniser, no reset so pins pass during reset
  // ========================================================================
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule : mrbs_sync

/* mrbs_trig.sv */
`timescale 1ns/1ps
`include "mrbs_cfg.svh"

module mrbs_trig (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic done,
  output logic      busy
);

  // ========================================================================
  // Auto-clearing trigger bit
  // ========================================================================
  // Start wins over a done in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;
    end
  end

endmodule : mrbs_trig
